// *** rgc_pkg.sv ***
// constants and types for the rx gain and regulator control block
// assumes a 32-bit apb master; register indices are word indices (byte address = 4 * index)
package rgc_pkg;

  localparam logic [5:0] IDX_CHIP_STATUS  = 6'h00;
  localparam logic [5:0] IDX_PROTOCOL     = 6'h01;
  localparam logic [5:0] IDX_RX_SPECIAL   = 6'h0A;
  localparam logic [5:0] IDX_SUPPLY_CTRL  = 6'h0B;
  localparam logic [5:0] IDX_AGC_STATUS   = 6'h10;
  localparam logic [5:0] IDX_SUPPLY_STAT  = 6'h11;

  localparam logic [7:0] CHIP_STATUS_RST  = 8'h00;
  localparam logic [7:0] PROTOCOL_RST     = 8'h00;
  localparam logic [7:0] RX_SPECIAL_RST   = 8'h40;
  localparam logic [7:0] SUPPLY_CTRL_RST  = 8'h87;
  localparam logic [7:0] SUPPLY_CTRL_MASK = 8'hE7;

  // chip status control fields
  localparam int CS_FIVE_VOLT_BIT = 0;
  localparam int CS_AGC_ON_BIT    = 2;
  // rx special setting fields
  localparam int RS_NO_LIM_BIT    = 0;
  localparam int RS_AGCR_BIT      = 1;
  localparam int RS_GAIN_LSB      = 2;
  localparam int RS_HBT_BIT       = 4;
  localparam int RS_M848_BIT      = 5;
  localparam int RS_C424_BIT      = 6;
  localparam int RS_C212_BIT      = 7;
  // supply and pin control fields
  localparam int SP_AUTO_BIT      = 7;
  localparam int SP_EXT_AMP_BIT   = 6;
  localparam int SP_IO_LOW_BIT    = 5;

  // agc sequence
  localparam logic [2:0] AGC_COMP_STEPS  = 3'h4;
  localparam logic [2:0] AGC_TOTAL_STEPS = 3'h7;
  localparam logic [3:0] AGC_WINDOW      = 4'h8;

  // supply rails in units of 10 mV
  localparam logic [9:0] V_STEP          = 10'h00A;
  localparam logic [9:0] V_RF5_BASE      = 10'h1AE;
  localparam logic [9:0] V_ANA5          = 10'h15E;
  localparam logic [9:0] V_AUX_MAX       = 10'h154;
  localparam logic [9:0] V_LOW3_BASE     = 10'h10E;
  localparam logic [9:0] V_HEAD_250      = 10'h019;
  localparam logic [9:0] V_HEAD_350      = 10'h023;
  localparam logic [9:0] V_HEAD_400      = 10'h028;

  typedef enum logic [2:0] {
    BAND_240K_1M4 = 3'h0,
    BAND_110K_570K = 3'h1,
    BAND_200K_900K = 3'h2,
    BAND_450K_1M5 = 3'h3,
    BAND_100K_1M5 = 3'h4
  } rgc_band_t;

  typedef enum logic [2:0] {
    AGC_IDLE  = 3'b000,
    AGC_ARMED = 3'b001,
    AGC_COMP  = 3'b011,
    AGC_GAIN  = 3'b010,
    AGC_DONE  = 3'b110
  } rgc_agc_state_t;

endpackage

// *** rgc_cfg_if.sv ***
// configuration bits passed from the register bank to the agc and supply decoders
// assumes all three modules share pclk
`timescale 1ns/100ps
interface rgc_cfg_if;
  logic       agc_on;
  logic       no_lim;
  logic       agcr;
  logic       five_volt;
  logic [7:0] supply_ctrl;

  modport ctrl (output agc_on, output no_lim, output agcr, output five_volt, output supply_ctrl);
  modport agc  (input agc_on, input no_lim, input agcr);
  modport sup  (input five_volt, input supply_ctrl);
endinterface

// *** rgc_agc.sv ***
// receiver agc sequencer: four comparator steps then three gain-reduction steps
// assumes tx/rx activity, subcarrier pulses and level flags are synchronous to pclk
`timescale 1ns/100ps
module rgc_agc
  import rgc_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  rgc_cfg_if.agc       cfg,
  input  wire logic    tx_active,
  input  wire logic    rx_active,
  input  wire logic    subcarrier_pulse,
  input  wire logic    level_over_3x,
  input  wire logic    level_over_5x,
  output logic [2:0]   comp_step,
  output logic [1:0]   gain_step,
  output logic         agc_running,
  output logic         agc_blocked
);

  typedef struct packed {
    rgc_agc_state_t state;
    logic [3:0]     pulses;
    logic [2:0]     step;
    logic           blocked;
  } rgc_agc_st_t;

  rgc_agc_st_t st_q;
  rgc_agc_st_t st_d;
  logic        window_open;
  logic        level_hit;

  assign window_open = cfg.no_lim || (st_q.pulses < AGC_WINDOW); // [R03] [R04]
  assign level_hit   = cfg.agcr ? level_over_3x : level_over_5x; // [R07]

  always_comb
  begin
    st_d = st_q;
    if (!cfg.agc_on || tx_active)
    begin
      // loop off: hold in idle; transmitting with the loop on: hold armed; both clear the steps [R02] [R06]
      st_d.state   = tx_active && cfg.agc_on ? AGC_ARMED : AGC_IDLE;
      st_d.pulses  = 4'h0;
      st_d.step    = 3'h0;
      st_d.blocked = 1'b0;
    end
    else
    begin
      unique case (st_q.state)
        AGC_IDLE:  st_d.state = AGC_IDLE;
        AGC_ARMED:
        begin
          if (rx_active)
            st_d.state = AGC_COMP; // only after tx has ended [R02]
        end
        AGC_COMP, AGC_GAIN:
        begin
          if (!rx_active)
            st_d.state = AGC_DONE;
          else if (subcarrier_pulse)
          begin
            if (st_q.pulses != 4'hF)
              st_d.pulses = st_q.pulses + 4'h1;
            if (!window_open)
            begin
              st_d.state   = AGC_DONE; // window closed [R03]
              st_d.blocked = 1'b1;
            end
            else if (level_hit) // [R06] [R07]
            begin
              st_d.step = st_q.step + 3'h1;
              if (st_q.step + 3'h1 >= AGC_TOTAL_STEPS)
                st_d.state = AGC_DONE;
              else if (st_q.step + 3'h1 >= AGC_COMP_STEPS)
                st_d.state = AGC_GAIN; // [R01]
            end
          end
        end
        AGC_DONE:  st_d.state = AGC_DONE;
        default:   st_d.state = AGC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '{state: AGC_IDLE, pulses: 4'h0, step: 3'h0, blocked: 1'b0};
    else
      st_q <= st_d;
  end

  // first four steps trim the comparator, the rest reduce gain [R01]
  assign comp_step   = (st_q.step > AGC_COMP_STEPS) ? AGC_COMP_STEPS : st_q.step;
  assign gain_step   = (st_q.step > AGC_COMP_STEPS) ? 2'(st_q.step - AGC_COMP_STEPS) : 2'h0;
  assign agc_running = (st_q.state == AGC_COMP) || (st_q.state == AGC_GAIN);
  assign agc_blocked = st_q.blocked;

endmodule // rgc_agc

// *** rgc_supply.sv ***
// regulator target decoder: rail set-points in 10 mV units from the supply control byte
// assumes vin_10mv is a measured input supply sample, synchronous to pclk
`timescale 1ns/100ps
module rgc_supply
  import rgc_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  rgc_cfg_if.sup       cfg,
  input  wire logic [9:0] vin_10mv,
  output logic [9:0]   rf_supply_rail,
  output logic [9:0]   analog_rail,
  output logic [9:0]   aux_rail,
  output logic [9:0]   headroom
);

  typedef struct packed {
    logic [9:0] rf;
    logic [9:0] ana;
    logic [9:0] aux;
    logic [9:0] head;
  } rgc_sup_st_t;

  rgc_sup_st_t st_q;
  rgc_sup_st_t st_d;
  logic [9:0]  code_mv;
  logic [9:0]  tracked;

  assign code_mv = 10'(cfg.supply_ctrl[2:0]) * V_STEP;

  always_comb
  begin
    st_d = st_q;
    // 01 is not a listed headroom; it is treated as the widest one
    unique case (cfg.supply_ctrl[1:0]) // [R16]
      2'b11:   st_d.head = V_HEAD_250;
      2'b10:   st_d.head = V_HEAD_350;
      default: st_d.head = V_HEAD_400;
    endcase
    tracked = (vin_10mv > st_d.head) ? 10'(vin_10mv - st_d.head) : 10'h000;
    if (cfg.supply_ctrl[SP_AUTO_BIT]) // [R10]
    begin
      st_d.rf  = tracked;
      st_d.ana = tracked;
      st_d.aux = (tracked > V_AUX_MAX) ? V_AUX_MAX : tracked; // [R17]
    end
    else if (cfg.five_volt)
    begin
      st_d.rf  = V_RF5_BASE + code_mv; // [R14]
      st_d.ana = V_ANA5;
      st_d.aux = V_AUX_MAX;
    end
    else
    begin
      st_d.rf  = V_LOW3_BASE + code_mv; // [R15]
      st_d.ana = V_LOW3_BASE + code_mv;
      st_d.aux = V_LOW3_BASE + code_mv;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rf_supply_rail = st_q.rf;
  assign analog_rail    = st_q.ana;
  assign aux_rail       = st_q.aux;
  assign headroom       = st_q.head;

endmodule // rgc_supply

// *** rgc_top.sv ***
// rx gain and regulator control: apb register bank, agc sequencer and supply decoder
// assumes a zero-wait apb master on pclk; the enable pin is sampled on pclk
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps

//Behaviour
// R01: agc uses four comparator-adjust steps, then three automatic gain-reduction steps
// R02: agc acts only after transmission has finished, never during transmit
// R03: unlimited-window bit clear confines agc to first 8 subcarrier pulses
// R04: no-limit bit B0 of rx special setting removes the post-window blocking
// R05: each protocol selection loads a preset filter setting; later writes override it
// R06: agc loop runs only while chip status B2 is set, watching digitizer level
// R07: gain reduction triggers at five times threshold, three times when B1 set
// R08: filter bits b7..b4 all zero select the 240 kHz to 1.4 MHz band
// R09: supply and pin control resets to 0x87 at power-on and while enable low
// R10: B7 set selects automatic regulation; clear uses manual code in B2..B0
// R11: B6 disables peak detectors, takes external subcarrier, drives modulation output
// R12: B5 keeps low-voltage io drive; host sets it for 1.8 to 2.7 V
// R13: B4 and B3 of supply control have no function and read zero
// R14: manual 5 V: code 111..000 gives rf rail 5.0..4.3 V, others fixed
// R15: manual 3 V: code 111..000 sets all rails 3.4..2.7 V together
// R16: automatic headroom from B1..B0: 11 250 mV, 10 350 mV, 00 400 mV
// R17: automatic aux rail tracks input less headroom, capped at 3.4 V
// R18: rx special setting resets to 0x40 at power-on, enable low, protocol write
// R19: supply control is read/write; a written value acts once the write completes
module rgc_top
  import rgc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chip_enable,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        subcarrier_pulse,
  input  wire logic        level_over_3x,
  input  wire logic        level_over_5x,
  input  wire logic [9:0]  vin_10mv,
  output logic [2:0]       filter_band,
  output logic [1:0]       gain_reduction,
  output logic [2:0]       comp_step,
  output logic [1:0]       gain_step,
  output logic             peak_detect_en,
  output logic             receiver_input_one_ext,
  output logic             receiver_input_two_ext,
  output logic             modulation_pin_oe,
  output logic             io_low_voltage_drive,
  output logic             external_amplifier_support,
  output logic             voltage_code_msb,
  output logic             voltage_code_mid,
  output logic             voltage_code_lsb,
  output logic [9:0]       rf_supply_rail,
  output logic [9:0]       analog_rail,
  output logic [9:0]       aux_rail,
  output logic [9:0]       headroom
);

  typedef struct packed {
    logic [7:0]  chip_status;
    logic [7:0]  protocol;
    logic [7:0]  rx_special;
    logic [7:0]  supply_ctrl;
    logic [31:0] rdata;
    logic        err;
  } rgc_top_st_t;

  rgc_top_st_t st_q;
  rgc_top_st_t st_d;

  rgc_cfg_if cfg ();

  logic       setup_ph;
  logic       access_ph;
  logic [5:0] idx;
  logic       aligned;
  logic       mapped;
  logic       writable;
  logic       agc_running;
  logic       agc_blocked;
  logic [7:0] agc_status;
  logic [7:0] supply_status;
  logic [7:0] wbyte;
  rgc_band_t  band;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign idx       = paddr[7:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign wbyte     = pstrb[0] ? pwdata[7:0] : 8'h00;

  always_comb
  begin
    unique case (idx)
      IDX_CHIP_STATUS, IDX_PROTOCOL, IDX_RX_SPECIAL, IDX_SUPPLY_CTRL:
      begin
        mapped   = 1'b1;
        writable = 1'b1;
      end
      IDX_AGC_STATUS, IDX_SUPPLY_STAT:
      begin
        mapped   = 1'b1;
        writable = 1'b0;
      end
      default:
      begin
        mapped   = 1'b0;
        writable = 1'b0;
      end
    endcase
  end

  assign agc_status    = {3'h0, agc_blocked, agc_running, comp_step == AGC_COMP_STEPS, gain_step};
  assign supply_status = {headroom[7:0]};

  always_comb
  begin
    st_d = st_q;
    // read data and error are captured in setup so the access phase answers at once
    if (setup_ph)
    begin
      st_d.err = !(aligned && mapped);
      unique case (idx)
        IDX_CHIP_STATUS: st_d.rdata = {24'h000000, st_q.chip_status};
        IDX_PROTOCOL:    st_d.rdata = {24'h000000, st_q.protocol};
        IDX_RX_SPECIAL:  st_d.rdata = {24'h000000, st_q.rx_special};
        IDX_SUPPLY_CTRL: st_d.rdata = {24'h000000, st_q.supply_ctrl}; // [R19]
        IDX_AGC_STATUS:  st_d.rdata = {24'h000000, agc_status};
        IDX_SUPPLY_STAT: st_d.rdata = {24'h000000, supply_status};
        default:         st_d.rdata = 32'h00000000;
      endcase
      if (!(aligned && mapped))
        st_d.rdata = 32'h00000000;
    end
    if (access_ph && pwrite && aligned && writable && pstrb[0])
    begin
      unique case (idx)
        IDX_CHIP_STATUS: st_d.chip_status = wbyte;
        IDX_PROTOCOL:
        begin
          st_d.protocol   = wbyte;
          // a new standard reloads the filter preset, overriding earlier trims [R05] [R18]
          st_d.rx_special = RX_SPECIAL_RST;
        end
        IDX_RX_SPECIAL:  st_d.rx_special = wbyte; // [R05]
        IDX_SUPPLY_CTRL: st_d.supply_ctrl = wbyte & SUPPLY_CTRL_MASK; // [R13] [R19]
        default:         st_d.chip_status = st_q.chip_status;
      endcase
    end
    // enable low holds the bank at its defaults, like power-on
    if (!chip_enable)
    begin
      st_d.chip_status = CHIP_STATUS_RST;
      st_d.protocol    = PROTOCOL_RST;
      st_d.rx_special  = RX_SPECIAL_RST;  // [R18]
      st_d.supply_ctrl = SUPPLY_CTRL_RST; // [R09]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '{chip_status: CHIP_STATUS_RST, protocol: PROTOCOL_RST,
                rx_special: RX_SPECIAL_RST, supply_ctrl: SUPPLY_CTRL_RST, // [R09] [R18]
                rdata: 32'h00000000, err: 1'b0};
    else
      st_q <= st_d;
  end

  assign pready  = 1'b1;
  assign prdata  = st_q.rdata;
  assign pslverr = access_ph && st_q.err;

  // configuration carried to the sequencer and the supply decoder
  assign cfg.agc_on      = st_q.chip_status[CS_AGC_ON_BIT]; // [R06]
  assign cfg.five_volt   = st_q.chip_status[CS_FIVE_VOLT_BIT];
  assign cfg.no_lim      = st_q.rx_special[RS_NO_LIM_BIT]; // [R04]
  assign cfg.agcr        = st_q.rx_special[RS_AGCR_BIT]; // [R07]
  assign cfg.supply_ctrl = st_q.supply_ctrl;

  // filter band: highest set select bit wins; none set gives the wide default
  always_comb
  begin
    if (st_q.rx_special[RS_C212_BIT])
      band = BAND_110K_570K;
    else if (st_q.rx_special[RS_C424_BIT])
      band = BAND_200K_900K;
    else if (st_q.rx_special[RS_M848_BIT])
      band = BAND_450K_1M5;
    else if (st_q.rx_special[RS_HBT_BIT])
      band = BAND_100K_1M5;
    else
      band = BAND_240K_1M4; // [R08]
  end

  assign filter_band    = band;
  assign gain_reduction = st_q.rx_special[RS_GAIN_LSB +: 2];

  // external amplifier mode swaps the receive path and the modulation pin role [R11]
  assign external_amplifier_support = st_q.supply_ctrl[SP_EXT_AMP_BIT];
  assign peak_detect_en             = !st_q.supply_ctrl[SP_EXT_AMP_BIT];
  assign receiver_input_one_ext     = st_q.supply_ctrl[SP_EXT_AMP_BIT];
  assign receiver_input_two_ext     = st_q.supply_ctrl[SP_EXT_AMP_BIT];
  assign modulation_pin_oe          = st_q.supply_ctrl[SP_EXT_AMP_BIT];
  assign io_low_voltage_drive       = st_q.supply_ctrl[SP_IO_LOW_BIT]; // [R12]
  assign voltage_code_msb           = st_q.supply_ctrl[2]; // [R10]
  assign voltage_code_mid           = st_q.supply_ctrl[1];
  assign voltage_code_lsb           = st_q.supply_ctrl[0];

  rgc_agc u_agc (
    .pclk             (pclk),
    .presetn          (presetn),
    .cfg              (cfg.agc),
    .tx_active        (tx_active),
    .rx_active        (rx_active),
    .subcarrier_pulse (subcarrier_pulse),
    .level_over_3x    (level_over_3x),
    .level_over_5x    (level_over_5x),
    .comp_step        (comp_step),
    .gain_step        (gain_step),
    .agc_running      (agc_running),
    .agc_blocked      (agc_blocked)
  );

  rgc_supply u_supply (
    .pclk           (pclk),
    .presetn        (presetn),
    .cfg            (cfg.sup),
    .vin_10mv       (vin_10mv),
    .rf_supply_rail (rf_supply_rail),
    .analog_rail    (analog_rail),
    .aux_rail       (aux_rail),
    .headroom       (headroom)
  );

endmodule // rgc_top

// *** rgc_checker.sv ***
// port-level assertions for rgc_top
// assumes binding by name onto rgc_top; one pclk domain
`timescale 1ns/100ps
module rgc_checker
  import rgc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        chip_enable,
  input wire logic        tx_active,
  input wire logic [2:0]  filter_band,
  input wire logic [1:0]  gain_reduction,
  input wire logic [2:0]  comp_step,
  input wire logic [1:0]  gain_step,
  input wire logic        peak_detect_en,
  input wire logic        modulation_pin_oe,
  input wire logic        io_low_voltage_drive,
  input wire logic        external_amplifier_support,
  input wire logic        voltage_code_msb,
  input wire logic        voltage_code_mid,
  input wire logic        voltage_code_lsb,
  input wire logic [9:0]  aux_rail,
  input wire logic [9:0]  headroom
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // zero-wait slave, so an access cycle with enable high is where a write lands
  wire acc    = psel && penable && pwrite && chip_enable;
  wire wr_sup = acc && paddr == 8'h2C;
  wire wr_rxs = acc && paddr == 8'h28;
  wire wr_pro = acc && paddr == 8'h04;
  property p_head;
    logic [1:0] c;
    (wr_sup && pwdata[7], c = pwdata[1:0]) |-> ##2
      headroom == (c == 2'h3 ? V_HEAD_250 : (c == 2'h2 ? V_HEAD_350 : V_HEAD_400));
  endproperty
  property p_wr;
    logic [7:0] v;
    (wr_sup, v = pwdata[7:0]) |=> {external_amplifier_support, io_low_voltage_drive,
      voltage_code_msb, voltage_code_mid, voltage_code_lsb} == {v[6:5], v[2:0]};
  endproperty
  property p_rxs;
    logic [7:0] v;
    (wr_rxs, v = pwdata[7:0]) |=> gain_reduction == v[3:2] && (v[7:4] != 4'h0 || filter_band == BAND_240K_1M4);
  endproperty
  a_auto_headroom: assert property (p_head) else $error("auto headroom wrong");
  a_supply_write: assert property (p_wr) else $error("supply control write not applied");
  a_band_default: assert property (p_rxs) else $error("rx special decode wrong");
  a_enable_reset: assert property (!chip_enable |=> {voltage_code_msb, voltage_code_mid, voltage_code_lsb} == 3'h7
    && !external_amplifier_support && !io_low_voltage_drive) else $error("enable low did not reset");
  a_proto_preset: assert property (wr_pro |=> filter_band == BAND_200K_900K && gain_reduction == 2'h0)
    else $error("protocol write did not preset filter");
  a_read_unused: assert property (psel && penable && !pwrite && paddr == 8'h2C |-> prdata[31:8] == 24'h0
    && prdata[4:3] == 2'h0) else $error("unused supply bits read nonzero");
  a_gain_order: assert property (gain_step != 2'h0 |-> comp_step == 3'h4)
    else $error("gain step before comparator steps");
  a_tx_clear: assert property (tx_active ##1 tx_active |-> comp_step == 3'h0 && gain_step == 2'h0)
    else $error("agc active during transmit");
  a_aux_cap: assert property (aux_rail <= V_AUX_MAX) else $error("aux rail above cap");
  a_ext_amp: assert property (peak_detect_en != external_amplifier_support
    && modulation_pin_oe == external_amplifier_support) else $error("external amplifier pins wrong");
  c_sup_write: cover property (wr_sup);
  c_gain_full: cover property (gain_step == 2'h3);
  c_proto: cover property (wr_pro);
endmodule // rgc_checker

bind rgc_top rgc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .chip_enable(chip_enable),
  .tx_active(tx_active), .filter_band(filter_band), .gain_reduction(gain_reduction),
  .comp_step(comp_step), .gain_step(gain_step), .peak_detect_en(peak_detect_en),
  .modulation_pin_oe(modulation_pin_oe), .io_low_voltage_drive(io_low_voltage_drive),
  .external_amplifier_support(external_amplifier_support), .voltage_code_msb(voltage_code_msb),
  .voltage_code_mid(voltage_code_mid), .voltage_code_lsb(voltage_code_lsb), .aux_rail(aux_rail),
  .headroom(headroom));

// *** rgc_host.sv ***
// host controller model: apb master reaching the control registers
// assumes the bench calls xfer one transfer at a time
`timescale 1ns/100ps
module rgc_host
(
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines are inverted so a stale value never passes for a live one
    paddr <= ~a;
    pwdata <= ~d;
    pstrb <= 4'h0;
  endtask
endmodule // rgc_host

// *** rx_gain_and_regulator_control_tb.sv ***
// self-checking bench for rgc_top driven by the host model
// assumes 10 MHz pclk and a 3-cycle reset at start
`timescale 1ns/100ps
module rx_gain_and_regulator_control_tb;
  import rgc_pkg::*;
  logic pclk, presetn, chip_enable, tx_active, rx_active, subcarrier_pulse, level_over_3x, level_over_5x;
  logic psel, penable, pwrite, pready, pslverr, peak, rx1, rx2, oe, iol, ext, vc2, vc1, vc0;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata;
  logic [2:0] filter_band, comp_step;
  logic [1:0] gain_reduction, gain_step;
  logic [9:0] vin_10mv, rf, ana, aux, headroom;
  int miscompares = 0, comparisons = 0;
  localparam logic [9:0] HD [4] = '{V_HEAD_400, V_HEAD_400, V_HEAD_350, V_HEAD_250};
  rgc_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  rgc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_enable(chip_enable), .tx_active(tx_active), .rx_active(rx_active),
    .subcarrier_pulse(subcarrier_pulse), .level_over_3x(level_over_3x), .level_over_5x(level_over_5x),
    .vin_10mv(vin_10mv), .filter_band(filter_band), .gain_reduction(gain_reduction),
    .comp_step(comp_step), .gain_step(gain_step), .peak_detect_en(peak), .receiver_input_one_ext(rx1),
    .receiver_input_two_ext(rx2), .modulation_pin_oe(oe), .io_low_voltage_drive(iol),
    .external_amplifier_support(ext), .voltage_code_msb(vc2), .voltage_code_mid(vc1),
    .voltage_code_lsb(vc0), .rf_supply_rail(rf), .analog_rail(ana), .aux_rail(aux), .headroom(headroom));
  always #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, {24'h0, d}, q, e);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, ex});
  endtask
  task automatic rails(input logic [9:0] r, input logic [9:0] a, input logic [9:0] x, input logic [9:0] h);
    repeat (2) @(posedge pclk);
    #1;
    chk({12'h0, rf, ana}, {12'h0, r, a});
    chk({12'h0, aux, headroom}, {12'h0, x, h});
  endtask
  function automatic logic [31:0] flags();
    return {23'h0, rx1, rx2, peak, oe, ext, iol, vc2, vc1, vc0};
  endfunction
  task automatic pulse(input logic l3, input logic l5);
    @(posedge pclk);
    subcarrier_pulse <= 1'b1;
    level_over_3x <= l3;
    level_over_5x <= l5;
    @(posedge pclk);
    subcarrier_pulse <= 1'b0;
  endtask
  task automatic t_reset;
    rails(10'h1DB, 10'h1DB, 10'h154, 10'h019);
    rd(8'h2C, 32'h87, 1'b0);
    rd(8'h28, 32'h40, 1'b0);
    rd(8'h44, 32'h19, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_supply;
    wr(8'h2C, 8'hFF);
    chk(flags(), 32'h1BF);
    rd(8'h2C, 32'hE7, 1'b0);
    wr(8'h2C, 8'h25);
    chk(flags(), 32'h04D);
    rd(8'h08, 32'h0, 1'b1);
    rd(8'h2D, 32'h0, 1'b1);
    $display("test supply done");
  endtask
  task automatic t_manual;
    wr(8'h00, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h2C, 8'(c));
      rails(10'h1AE + 10'(c) * 10'h00A, 10'h15E, 10'h154, HD[c[1:0]]);
    end
    wr(8'h00, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h2C, 8'(c));
      rails(10'h10E + 10'(c) * 10'h00A, 10'h10E + 10'(c) * 10'h00A, 10'h10E + 10'(c) * 10'h00A, HD[c[1:0]]);
    end
    $display("test manual done");
  endtask
  task automatic t_auto;
    wr(8'h2C, 8'h83);
    rails(10'h1DB, 10'h1DB, 10'h154, 10'h019);
    wr(8'h2C, 8'h86);
    rails(10'h1D1, 10'h1D1, 10'h154, 10'h023);
    wr(8'h2C, 8'h84);
    rails(10'h1CC, 10'h1CC, 10'h154, 10'h028);
    @(posedge pclk) vin_10mv <= 10'h12C;
    wr(8'h2C, 8'h87);
    rails(10'h113, 10'h113, 10'h113, 10'h019);
    $display("test auto done");
  endtask
  task automatic t_filter;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h28, 8'h80 >> i);
      chk({29'h0, filter_band}, (i == 4) ? 32'h0 : 32'(i + 1));
    end
    wr(8'h04, 8'h00);
    chk({27'h0, filter_band, gain_reduction}, {27'h0, BAND_200K_900K, 2'h0});
    rd(8'h28, 32'h40, 1'b0);
    $display("test filter done");
  endtask
  task automatic t_enable;
    wr(8'h2C, 8'h00);
    @(posedge pclk) chip_enable <= 1'b0;
    wr(8'h2C, 8'h05);
    @(posedge pclk) chip_enable <= 1'b1;
    rd(8'h2C, 32'h87, 1'b0);
    $display("test enable done");
  endtask
  task automatic run_agc(input logic [7:0] cs, input logic [7:0] sp, input logic l3, input logic l5,
                         input int pre, input int n, input logic [2:0] ec, input logic [1:0] eg);
    wr(8'h00, cs);
    wr(8'h28, sp);
    @(posedge pclk) tx_active <= 1'b1;
    pulse(l3, l5);
    @(posedge pclk) tx_active <= 1'b0;
    @(posedge pclk) rx_active <= 1'b1;
    repeat (pre) pulse(1'b0, 1'b0);
    repeat (n) pulse(l3, l5);
    #1;
    chk({27'h0, comp_step, gain_step}, {27'h0, ec, eg});
    @(posedge pclk) rx_active <= 1'b0;
  endtask
  task automatic t_agc;
    run_agc(8'h04, 8'h00, 1'b1, 1'b1, 0, 7, 3'h4, 2'h3);
    run_agc(8'h04, 8'h00, 1'b1, 1'b0, 0, 3, 3'h0, 2'h0);
    run_agc(8'h04, 8'h02, 1'b1, 1'b0, 0, 3, 3'h3, 2'h0);
    run_agc(8'h04, 8'h00, 1'b1, 1'b1, 7, 2, 3'h1, 2'h0);
    rd(8'h40, 32'h10, 1'b0);
    run_agc(8'h04, 8'h01, 1'b1, 1'b1, 8, 2, 3'h2, 2'h0);
    run_agc(8'h00, 8'h00, 1'b1, 1'b1, 0, 3, 3'h0, 2'h0);
    $display("test agc done");
  endtask
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    chip_enable = 1'b1;
    tx_active = 1'b0;
    rx_active = 1'b0;
    subcarrier_pulse = 1'b0;
    level_over_3x = 1'b0;
    level_over_5x = 1'b0;
    vin_10mv = 10'h1F4;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_supply();
    t_manual();
    t_auto();
    t_filter();
    t_enable();
    t_agc();
    test_done();
  end
  // the tests need well under 1000 cycles; twenty thousand leaves a wide margin
  initial
  begin
    #(100 * 20000);
    miscompares++;
    test_done();
  end
endmodule // rx_gain_and_regulator_control_tb
